// file: logic/apgs_pkg.sv
// package: constants, types and helpers for the phase/gain/status register bank
package apgs_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam int NCH = 4;
  localparam int DELAY_W = 12;
  localparam int GAIN_W = 3;
  localparam int CTRL_W = 10;

  // ------------------------------------------------------------
  // register offsets and map bounds
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_DELAY = 5'h0A;
  localparam logic [4:0] ADDR_GAIN = 5'h0B;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_DATA_LAST = 5'h03;
  localparam logic [4:0] ADDR_CFG_FIRST = 5'h08;
  localparam logic [4:0] ADDR_CTRL_FIRST = 5'h0C;
  localparam logic [4:0] ADDR_CTRL_LAST = 5'h0E;
  localparam logic [4:0] ADDR_CAL_FIRST = 5'h0F;
  localparam logic [4:0] ADDR_CAL_LAST = 5'h16;
  localparam logic [4:0] ADDR_MAP_FIRST = 5'h00;
  localparam logic [4:0] ADDR_MAP_LAST = 5'h1F;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int UPPER_DELAY_LSB = 12;
  localparam int LOWER_DELAY_LSB = 0;
  localparam int GAIN_FIELD_W = 12;
  localparam int CTRL_LSB = 14;
  localparam int READ_MODE_LSB = 22;
  localparam int WRITE_INC_BIT = 21;
  localparam int IDLE_FLOAT_BIT = 20;
  localparam int MERGE_BIT = 19;
  localparam int CRC_WIDTH_BIT = 18;
  localparam int DATA_FMT_LSB = 16;
  localparam int LINK_CRC_BIT = 15;
  localparam int ALARM_EN_BIT = 14;

  // ------------------------------------------------------------
  // reset values and keys
  // ------------------------------------------------------------
  localparam logic [11:0] DELAY_RST = 12'h000;
  localparam logic [11:0] GAIN_RST = 12'h000;
  localparam logic [9:0] CTRL_RST = 10'h2A4;
  localparam logic [3:0] FLAGS_RST = 4'hF;
  localparam logic [7:0] LOCK_PASSWORD = 8'hA5;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 125;
  localparam int MOD_DIV_DEFAULT = 4;
  localparam int PULSE_MOD_PERIODS = 1;

  typedef enum logic [1:0] {
    APGS_RD_SAME = 2'b00,
    APGS_RD_GROUP = 2'b01,
    APGS_RD_TYPE = 2'b10,
    APGS_RD_MAP = 2'b11
  } apgs_rd_mode_t;

  typedef enum logic [1:0] {
    APGS_FMT_16_ROUND = 2'b00,
    APGS_FMT_24 = 2'b01,
    APGS_FMT_32_ZERO = 2'b10,
    APGS_FMT_32_SIGN = 2'b11
  } apgs_data_fmt_t;

  typedef enum logic [0:0] {
    APGS_PULSE_IDLE = 1'b0,
    APGS_PULSE_LOW = 1'b1
  } apgs_pulse_state_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // gain code to log2 of the gain; reserved codes act as unity
  function automatic logic [2:0] apgs_gain_log2(input logic [2:0] code);
    apgs_gain_log2 = (code > 3'h5) ? 3'h0 : code;
  endfunction

  // undefined holes in the map are skipped
  function automatic logic [4:0] apgs_step(input logic [4:0] a);
    if (a == ADDR_DATA_LAST) begin
      apgs_step = ADDR_CFG_FIRST;
    end else if (a == ADDR_CAL_LAST) begin
      apgs_step = ADDR_MAP_LAST;
    end else begin
      apgs_step = a + 5'h01;
    end
  endfunction

  function automatic logic [4:0] apgs_loop(input logic [4:0] a, input logic [4:0] lo,
                                           input logic [4:0] hi);
    apgs_loop = (a == hi) ? lo : apgs_step(a);
  endfunction

  function automatic logic [4:0] apgs_next_rd(input logic [4:0] a, input logic [1:0] mode);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = a;
    hi = a;
    case (mode)
      APGS_RD_MAP: begin
        lo = ADDR_MAP_FIRST;
        hi = ADDR_MAP_LAST;
      end
      APGS_RD_TYPE: begin
        lo = (a <= ADDR_DATA_LAST) ? ADDR_MAP_FIRST : ADDR_CFG_FIRST;
        hi = (a <= ADDR_DATA_LAST) ? ADDR_DATA_LAST : ADDR_MAP_LAST;
      end
      APGS_RD_GROUP: begin
        if (a <= ADDR_DATA_LAST) begin
          lo = {a[4:1], 1'b0};
          hi = {a[4:1], 1'b1};
        end else if (a < ADDR_CTRL_FIRST) begin
          lo = ADDR_CFG_FIRST;
          hi = ADDR_CTRL_FIRST - 5'h01;
        end else if (a <= ADDR_CTRL_LAST) begin
          lo = ADDR_CTRL_FIRST;
          hi = ADDR_CTRL_LAST;
        end else if (a <= ADDR_CAL_LAST) begin
          lo = a[0] ? a : a - 5'h01;
          hi = a[0] ? a + 5'h01 : a;
        end
      end
      default: begin
        lo = a;
        hi = a;
      end
    endcase
    apgs_next_rd = (lo == hi) ? a : apgs_loop(a, lo, hi);
  endfunction

  function automatic logic [4:0] apgs_next_wr(input logic [4:0] a, input logic inc);
    apgs_next_wr = inc ? apgs_loop(a, ADDR_CFG_FIRST, ADDR_MAP_LAST) : a;
  endfunction

endpackage

// file: logic/apgs_ready_pulse.sv
// low-going ready pulse timer counted in modulator clock periods
`timescale 1ns/1ps
module apgs_ready_pulse #(
  parameter int LEN = apgs_pkg::PULSE_MOD_PERIODS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mod_tick,
  input wire logic trigger,
  output logic active
);

  initial begin
    if (LEN < 1 || LEN > 255) begin
      $error("pulse length out of range");
    end
  end

  apgs_pkg::apgs_pulse_state_t state;
  logic [7:0] ticks;

  // ------------------------------------------------------------
  // pulse state
  // ------------------------------------------------------------
  // a new trigger restarts the count, so back to back events merge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= apgs_pkg::APGS_PULSE_IDLE;
      ticks <= 8'h00;
    end else begin
      case (state)
        apgs_pkg::APGS_PULSE_IDLE: begin
          ticks <= 8'h00;
          if (trigger) begin
            state <= apgs_pkg::APGS_PULSE_LOW;
          end
        end
        apgs_pkg::APGS_PULSE_LOW: begin
          if (trigger) begin
            ticks <= 8'h00;
          end else if (mod_tick) begin
            if (ticks == 8'(LEN - 1)) begin
              state <= apgs_pkg::APGS_PULSE_IDLE;
            end
            ticks <= ticks + 8'h01;
          end
        end
        default: begin
          state <= apgs_pkg::APGS_PULSE_IDLE;
        end
      endcase
    end
  end

  assign active = (state == apgs_pkg::APGS_PULSE_LOW);

endmodule

// file: logic/apgs_regs.sv
// phase delay, gain and status/link-control register bank with ready pin
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module apgs_regs #(
  parameter int MOD_DIV = apgs_pkg::MOD_DIV_DEFAULT,
  parameter int PULSE_LEN = apgs_pkg::PULSE_MOD_PERIODS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [23:0] reg_rdata,
  output logic [4:0] next_read_addr,
  output logic [4:0] next_write_addr,
  input wire logic [3:0] adc_active,
  input wire logic [3:0] ch_ready_evt,
  input wire logic config_checksum_fail,
  input wire logic lock_wr_en,
  input wire logic [7:0] lock_value,
  output logic [3:0] converter_restart,
  output logic [11:0] upper_pair_delay,
  output logic [11:0] lower_pair_delay,
  output logic [11:0] channel_gain_log2,
  output logic [1:0] read_incr_mode,
  output logic write_incr,
  output logic ready_pulse_merge,
  output logic checksum_wide,
  output logic [1:0] data_format,
  output logic link_checksum_enable,
  output logic [3:0] channel_latch,
  output logic ready_strobe_out,
  output logic ready_strobe_oe_n,
  output logic modulator_tick
);

  initial begin
    if (MOD_DIV < 2 || MOD_DIV > 255) begin
      $error("modulator divider out of range");
    end
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // modulator clock enable
  // ------------------------------------------------------------
  logic [7:0] div_cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      modulator_tick <= 1'b0;
    end else begin
      modulator_tick <= (div_cnt == 8'(MOD_DIV - 1));
      div_cnt <= (div_cnt == 8'(MOD_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic wr_delay;
  logic wr_gain;
  logic wr_status;
  logic rd_status;
  logic [11:0] gain_reg;
  logic [9:0] ctrl_reg;
  logic [3:0] ready_flags;
  logic alarm;
  logic alarm_en;
  logic alarm_shown;
  logic idle_float;
  logic lock_clear;

  assign wr_delay = reg_wr_en && (reg_addr == apgs_pkg::ADDR_DELAY);
  assign wr_gain = reg_wr_en && (reg_addr == apgs_pkg::ADDR_GAIN);
  assign wr_status = reg_wr_en && (reg_addr == apgs_pkg::ADDR_STATUS);
  assign rd_status = reg_rd_en && (reg_addr == apgs_pkg::ADDR_STATUS);
  assign alarm_en = ctrl_reg[apgs_pkg::ALARM_EN_BIT - apgs_pkg::CTRL_LSB];
  assign idle_float = !ctrl_reg[apgs_pkg::IDLE_FLOAT_BIT - apgs_pkg::CTRL_LSB];
  assign lock_clear = lock_wr_en && (lock_value == apgs_pkg::LOCK_PASSWORD);

  // ------------------------------------------------------------
  // delay register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_pair_delay <= apgs_pkg::DELAY_RST;
      lower_pair_delay <= apgs_pkg::DELAY_RST;
    end else if (wr_delay) begin
      upper_pair_delay <= reg_wdata[apgs_pkg::UPPER_DELAY_LSB +: apgs_pkg::DELAY_W];
      lower_pair_delay <= reg_wdata[apgs_pkg::LOWER_DELAY_LSB +: apgs_pkg::DELAY_W];
    end
  end

  // whatever is written, only running converters get a restart
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_restart <= 4'h0;
    end else begin
      converter_restart <= wr_delay ? adc_active : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // gain register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= apgs_pkg::GAIN_RST;
    end else if (wr_gain) begin
      gain_reg <= reg_wdata[apgs_pkg::GAIN_FIELD_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_gain_log2 <= 12'h000;
    end else begin
      for (int i = 0; i < apgs_pkg::NCH; i++) begin
        channel_gain_log2[i*3 +: 3] <= apgs_pkg::apgs_gain_log2(gain_reg[i*3 +: 3]);
      end
    end
  end

  // ------------------------------------------------------------
  // status and link control
  // ------------------------------------------------------------
  // reserved bits 13:12 are not stored; the host keeps them at zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= apgs_pkg::CTRL_RST;
    end else if (wr_status) begin
      ctrl_reg <= reg_wdata[23:apgs_pkg::CTRL_LSB];
    end
  end

  assign read_incr_mode = ctrl_reg[apgs_pkg::READ_MODE_LSB - apgs_pkg::CTRL_LSB +: 2];
  assign write_incr = ctrl_reg[apgs_pkg::WRITE_INC_BIT - apgs_pkg::CTRL_LSB];
  assign ready_pulse_merge = ctrl_reg[apgs_pkg::MERGE_BIT - apgs_pkg::CTRL_LSB];
  assign checksum_wide = ctrl_reg[apgs_pkg::CRC_WIDTH_BIT - apgs_pkg::CTRL_LSB];
  assign data_format = ctrl_reg[apgs_pkg::DATA_FMT_LSB - apgs_pkg::CTRL_LSB +: 2];
  assign link_checksum_enable = ctrl_reg[apgs_pkg::LINK_CRC_BIT - apgs_pkg::CTRL_LSB];

  // ------------------------------------------------------------
  // address sequencing
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_read_addr <= apgs_pkg::ADDR_MAP_FIRST;
      next_write_addr <= apgs_pkg::ADDR_CFG_FIRST;
    end else begin
      if (reg_rd_en) begin
        next_read_addr <= apgs_pkg::apgs_next_rd(reg_addr, read_incr_mode);
      end
      if (reg_wr_en) begin
        next_write_addr <= apgs_pkg::apgs_next_wr(reg_addr, write_incr);
      end
    end
  end

  // ------------------------------------------------------------
  // ready flags
  // ------------------------------------------------------------
  // a conversion landing in the read cycle wins, so no event is lost;
  // channel data reads and host writes have no path in here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_flags <= apgs_pkg::FLAGS_RST;
    end else begin
      ready_flags <= (rd_status ? apgs_pkg::FLAGS_RST : ready_flags) & ~ch_ready_evt;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
    end else if (reg_rd_en) begin
      case (reg_addr)
        apgs_pkg::ADDR_DELAY: reg_rdata <= {upper_pair_delay, lower_pair_delay};
        apgs_pkg::ADDR_GAIN: reg_rdata <= {12'h000, gain_reg};
        apgs_pkg::ADDR_STATUS: reg_rdata <= {ctrl_reg, 2'b00, 8'h00, ready_flags};
        default: reg_rdata <= 24'h000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // ready merging
  // ------------------------------------------------------------
  logic [3:0] ready_seen;
  logic [3:0] seen_all;
  logic merge_fire;
  logic pulse_trigger;
  logic pulse_active;

  // the merged pulse waits for the most lagging active converter
  assign seen_all = (ready_seen | ch_ready_evt) & adc_active;
  assign merge_fire = ready_pulse_merge && (adc_active != 4'h0) && (seen_all == adc_active)
                      && ((ch_ready_evt & adc_active) != 4'h0);
  assign pulse_trigger = ready_pulse_merge ? merge_fire : (ch_ready_evt != 4'h0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_seen <= 4'h0;
    end else if (wr_delay || merge_fire || !ready_pulse_merge) begin
      ready_seen <= 4'h0;
    end else begin
      ready_seen <= seen_all;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_latch <= 4'h0;
    end else if (ready_pulse_merge) begin
      channel_latch <= merge_fire ? 4'hF : 4'h0;
    end else begin
      channel_latch <= ch_ready_evt;
    end
  end

  apgs_ready_pulse #(
    .LEN(PULSE_LEN)
  ) u_pulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .mod_tick(modulator_tick),
    .trigger(pulse_trigger),
    .active(pulse_active)
  );

  // ------------------------------------------------------------
  // checksum alarm
  // ------------------------------------------------------------
  // failure arriving with the password write still latches
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm <= 1'b0;
    end else if (alarm_en && config_checksum_fail) begin
      alarm <= 1'b1;
    end else if (lock_clear) begin
      alarm <= 1'b0;
    end
  end

  assign alarm_shown = alarm && alarm_en;

  // ------------------------------------------------------------
  // ready pin
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_strobe_out <= 1'b1;
      ready_strobe_oe_n <= 1'b1;
    end else begin
      ready_strobe_out <= !(pulse_active || alarm_shown);
      ready_strobe_oe_n <= !(pulse_active || alarm_shown || !idle_float);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_delay_wr;
    wr_delay;
  endsequence

  sequence s_merge_done;
    merge_fire ##1 (channel_latch == 4'hF);
  endsequence

  restart_pulse_a: assert property (s_delay_wr |=> converter_restart == $past(adc_active))
    else $error("restart does not follow active mask");
  restart_quiet_a: assert property (!wr_delay |=> converter_restart == 4'h0)
    else $error("restart without delay write");
  upper_delay_a: assert property (s_delay_wr |=> upper_pair_delay == $past(reg_wdata[23:12]))
    else $error("upper delay not stored");
  lower_delay_a: assert property (s_delay_wr |=> lower_pair_delay == $past(reg_wdata[11:0]))
    else $error("lower delay not stored");
  gain_reserved_a: assert property (gain_reg[2:0] > 3'h5 |=> channel_gain_log2[2:0] == 3'h0)
    else $error("reserved gain code not unity");
  gain_max_a: assert property (gain_reg[11:9] == 3'h5 |=> channel_gain_log2[11:9] == 3'h5)
    else $error("gain 32 not decoded");
  flags_read_a: assert property (rd_status && ch_ready_evt == 4'h0 |=> ready_flags == 4'hF)
    else $error("flags not restored by status read");
  flags_event_a: assert property (ch_ready_evt[0] |=> !ready_flags[0])
    else $error("ready event lost");
  flags_hold_a: assert property (!rd_status && ch_ready_evt == 4'h0 |=> $stable(ready_flags))
    else $error("flags changed without cause");
  alarm_hold_a: assert property (alarm_shown && !lock_clear && !wr_status |=>
    alarm ##1 !ready_strobe_out)
    else $error("alarm not held on pin");
  alarm_clear_a: assert property (lock_clear && !config_checksum_fail |=> !alarm)
    else $error("password did not clear alarm");
  alarm_gate_a: assert property (!alarm_en && !alarm |=> !alarm)
    else $error("alarm raised while disabled");
  pin_float_a: assert property (!pulse_active && !alarm_shown && idle_float |=> ready_strobe_oe_n)
    else $error("idle pin not floating");
  merge_latch_a: assert property (merge_fire |-> s_merge_done)
    else $error("merged latch missing");
  pulse_low_a: assert property ($rose(pulse_active) |=> !ready_strobe_out && !ready_strobe_oe_n)
    else $error("ready pulse not driven low");

endmodule

// file: bench/apgs_host_model.sv
// host-side model driving the register strobe port of the bank
`timescale 1ns/1ps
module apgs_host_model (
  input wire logic core_clk,
  input wire logic [23:0] reg_rdata,
  output logic [4:0] reg_addr,
  output logic reg_wr_en,
  output logic [23:0] reg_wdata,
  output logic reg_rd_en
);
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    reg_addr = 5'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 24'h000000;
    reg_rd_en = 1'b0;
  end

  // released data shows the inverse of the last word, never a stale copy
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    logic [23:0] w;
    w = d;
    if (a == apgs_pkg::ADDR_STATUS) begin
      w[13:12] = 2'h0;
    end
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~w;
  endtask

  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule

// file: bench/afe_phase_gain_status_regs_bench.sv
// self-checking bench for the phase, gain and status register bank
`timescale 1ns/1ps
module afe_phase_gain_status_regs_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] adc_active = 4'h0;
  logic [3:0] ch_ready_evt = 4'h0;
  logic config_checksum_fail = 1'b0;
  logic lock_wr_en = 1'b0;
  logic [7:0] lock_value = 8'h00;
  logic [4:0] reg_addr;
  logic reg_wr_en, reg_rd_en, write_incr, ready_pulse_merge, checksum_wide;
  logic link_checksum_enable, ready_strobe_out, ready_strobe_oe_n;
  logic [23:0] reg_wdata, reg_rdata, rd;
  logic [3:0] converter_restart, channel_latch;
  logic [11:0] upper_pair_delay, lower_pair_delay, channel_gain_log2;
  logic [1:0] read_incr_mode, data_format;
  logic [4:0] next_read_addr, next_write_addr;
  logic modulator_tick;
  int miscompares = 0;
  int n_tests = 0;

  always #4 core_clk = ~core_clk;

  apgs_host_model u_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));

  apgs_regs u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .next_read_addr(next_read_addr), .next_write_addr(next_write_addr),
    .adc_active(adc_active),
    .ch_ready_evt(ch_ready_evt), .config_checksum_fail(config_checksum_fail),
    .lock_wr_en(lock_wr_en), .lock_value(lock_value), .converter_restart(converter_restart),
    .upper_pair_delay(upper_pair_delay), .lower_pair_delay(lower_pair_delay),
    .channel_gain_log2(channel_gain_log2), .read_incr_mode(read_incr_mode),
    .write_incr(write_incr), .ready_pulse_merge(ready_pulse_merge),
    .checksum_wide(checksum_wide), .data_format(data_format),
    .link_checksum_enable(link_checksum_enable), .channel_latch(channel_latch),
    .ready_strobe_out(ready_strobe_out), .ready_strobe_oe_n(ready_strobe_oe_n),
    .modulator_tick(modulator_tick));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // pulse length depends on the modulator tick phase, so poll with a bound
  task automatic wait_pin(input logic v);
    int i;
    for (i = 0; i < 40 && ready_strobe_out !== v; i++) begin
      @(negedge core_clk);
    end
    if (i == 40) begin
      chk("ready pin wait", 24'h000001, 24'h000000);
      final_report();
    end
  endtask

  task automatic evt(input logic [3:0] e);
    @(posedge core_clk);
    ch_ready_evt <= e;
    @(posedge core_clk);
    ch_ready_evt <= 4'h0;
    @(negedge core_clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      n += modulator_tick;
    end
    chk("tick rate", 24'(n), 24'(8 / apgs_pkg::MOD_DIV_DEFAULT));
    u_host.rd(apgs_pkg::ADDR_DELAY, rd);
    chk("delay reset", rd, 24'h000000);
    u_host.rd(apgs_pkg::ADDR_GAIN, rd);
    chk("gain reset", rd, 24'h000000);
    u_host.rd(apgs_pkg::ADDR_STATUS, rd);
    chk("status reset", rd, 24'hA9000F);
    chk("read step", next_read_addr, 24'h00000D);
    chk("fields reset", {read_incr_mode, write_incr, ready_pulse_merge, data_format,
      ready_strobe_oe_n}, 24'h00005B);
  endtask

  task automatic t_delay();
    @(posedge core_clk);
    adc_active <= 4'h5;
    u_host.wr(apgs_pkg::ADDR_DELAY, 24'hABC123);
    @(negedge core_clk);
    chk("restart", converter_restart, 24'h000005);
    chk("write step", next_write_addr, 24'h00000B);
    chk("upper delay", upper_pair_delay, 24'h000ABC);
    chk("lower delay", lower_pair_delay, 24'h000123);
    @(negedge core_clk);
    chk("restart end", converter_restart, 24'h000000);
  endtask

  task automatic t_gain();
    for (int c = 0; c < 8; c++) begin
      u_host.wr(apgs_pkg::ADDR_GAIN, {12'hFFF, {4{c[2:0]}}});
      repeat (2) @(negedge core_clk);
      chk("gain code", channel_gain_log2, {12'h000, {4{(c > 5) ? 3'h0 : c[2:0]}}});
      u_host.rd(apgs_pkg::ADDR_GAIN, rd);
      chk("gain read", rd, {12'h000, {4{c[2:0]}}});
    end
  endtask

  // per-channel pulses with a driven idle level; flags written as 0 read back unchanged as F
  task automatic t_flags();
    u_host.wr(apgs_pkg::ADDR_STATUS, 24'h548000);
    @(negedge core_clk);
    chk("ctrl", {read_incr_mode, write_incr, ready_pulse_merge, checksum_wide, data_format,
      link_checksum_enable}, 24'h000049);
    u_host.rd(apgs_pkg::ADDR_STATUS, rd);
    chk("status ctrl", rd, 24'h54800F);
    u_host.wr(apgs_pkg::ADDR_GAIN, 24'h000000);
    @(negedge core_clk);
    chk("write same", next_write_addr, 24'h00000B);
    evt(4'h2);
    chk("latch one", channel_latch, 24'h000002);
    wait_pin(1'b0);
    chk("pin driven low", ready_strobe_oe_n, 24'h000000);
    wait_pin(1'b1);
    chk("idle driven", ready_strobe_oe_n, 24'h000000);
    u_host.rd(5'h00, rd);
    chk("data read", rd, 24'h000000);
    chk("group step", next_read_addr, 24'h000001);
    u_host.rd(apgs_pkg::ADDR_STATUS, rd);
    chk("flag ready", rd, 24'h54800D);
    u_host.rd(apgs_pkg::ADDR_STATUS, rd);
    chk("flag cleared", rd, 24'h54800F);
  endtask

  task automatic t_merge_alarm();
    u_host.wr(apgs_pkg::ADDR_STATUS, 24'hF94000);
    @(posedge core_clk);
    adc_active <= 4'h3;
    u_host.wr(apgs_pkg::ADDR_DELAY, 24'h000000);
    evt(4'h1);
    chk("no early latch", channel_latch, 24'h000000);
    evt(4'h2);
    chk("merged latch", channel_latch, 24'h00000F);
    wait_pin(1'b0);
    wait_pin(1'b1);
    @(posedge core_clk);
    config_checksum_fail <= 1'b1;
    @(posedge core_clk);
    config_checksum_fail <= 1'b0;
    wait_pin(1'b0);
    repeat (12) @(negedge core_clk);
    chk("alarm held", ready_strobe_out, 24'h000000);
    @(posedge core_clk);
    lock_value <= apgs_pkg::LOCK_PASSWORD;
    lock_wr_en <= 1'b1;
    @(posedge core_clk);
    lock_wr_en <= 1'b0;
    wait_pin(1'b1);
    u_host.wr(apgs_pkg::ADDR_STATUS, 24'h548000);
    @(posedge core_clk);
    config_checksum_fail <= 1'b1;
    @(posedge core_clk);
    config_checksum_fail <= 1'b0;
    repeat (8) @(negedge core_clk);
    chk("alarm off", ready_strobe_out, 24'h000001);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_delay();
    t_gain();
    t_flags();
    t_merge_alarm();
    final_report();
  end
endmodule
